// >>> hw/eepc_defs.svh
// Constants for the EEPROM program and erase controller: map, fields, resets, timing.
`ifndef EEPC_DEFS_SVH
`define EEPC_DEFS_SVH

// Register and cell addresses on the internal CPU bus.
`define EEPC_ADDR_BLOCK_PROTECT   16'h1035
`define EEPC_ADDR_PROGRAM_CONTROL 16'h103B
`define EEPC_ADDR_SETUP_CELL      16'h103F
`define EEPC_ADDR_ARRAY_BASE      16'hFE00

// Program control register fields.
`define EEPC_PC_ODD   7
`define EEPC_PC_EVEN  6
`define EEPC_PC_BYTE  4
`define EEPC_PC_ROW   3
`define EEPC_PC_ERASE 2
`define EEPC_PC_LATCH 1
`define EEPC_PC_PGM   0

// Block protect register fields.
`define EEPC_BP_SETUP 4
`define EEPC_BP_MSB   3

// Reset values.
`define EEPC_PC_RESET 8'h00
`define EEPC_BP_RESET 5'h1F
`define EEPC_ERASED   8'hFF

// Region boundaries inside the 512-byte array, as array offsets.
`define EEPC_REGION1_START 9'h020
`define EEPC_REGION2_START 9'h060
`define EEPC_REGION3_START 9'h0E0

// Timing: E clock period, protect window in E cycles, internal RC clock period.
`define EEPC_CLK_PERIOD_NS    10
`define EEPC_E_PERIOD_NS      500
`define EEPC_E_DIV            (`EEPC_E_PERIOD_NS / `EEPC_CLK_PERIOD_NS)
`define EEPC_PROTECT_WINDOW_E 64
`define EEPC_RC_PERIOD_NS     1000
`define EEPC_RC_DIV           (`EEPC_RC_PERIOD_NS / `EEPC_CLK_PERIOD_NS)

`endif

// >>> hw/eepc_pkg.sv
// Types shared by the EEPROM program and erase controller.
package eepc_pkg;

    // One access of the CPU core on the internal bus.
    typedef struct packed {
        logic [15:0] addr;
        logic        wr;
        logic        rd;
        logic [7:0]  data;
    } eepc_bus_req_t;

    // Operation that the high-voltage phase carries out.
    typedef enum logic [1:0] {
        EEPC_OP_PROGRAM = 2'b00,
        EEPC_OP_BYTE    = 2'b01,
        EEPC_OP_ROW     = 2'b10,
        EEPC_OP_BULK    = 2'b11
    } eepc_op_t;

endpackage : eepc_pkg

// >>> hw/eepc_ctrl.sv
// EEPROM program and erase controller with block protection and array storage.
//
// Behaviour
// - Protect bits clear to zero only in first 64 E cycles after reset.
// - A protect bit set after the first 64 E cycles keeps its region protected until reset.
// - Setup-cell protect bit blocks program and erase of the setup cell.
// - Four region protect bits guard 32, 64, 128 and 288 byte regions.
// - Protection affects program and erase only; reads return data normally.
// - Setting latch and voltage together before a latch-only write sets neither.
// - While voltage is on, writes to EEPROM are ignored, operation undisturbed.
// - No EEPROM write between latch and voltage means no operation.
// - Latch clear: EEPROM reads behave like ROM.
// - Programming, erase bit zero, ignores byte and row select.
// - Row erase takes any row address; bulk takes any array address.
// - Bulk erase latched at setup cell erases cell and whole array.
// - Size select: 00 bulk, 01 row of 16, byte bit set single byte.
// - Control register layout fixed; bit 5 reads zero; resets to zero.
// - Erase bit readable and writable any time; one selects erase.
// - Latch set: writes to EEPROM capture address and data.
// - Voltage bit readable any time, writable only while latch is one.
`timescale 1ns/1ns
`default_nettype none
`include "eepc_defs.svh"

module eepc_ctrl
    import eepc_pkg::*;
#(
    parameter int E_DIV  = `EEPC_E_DIV,
    parameter int RC_DIV = `EEPC_RC_DIV
) (
    // Clock and reset.
    input  wire logic          i_clock,
    input  wire logic          i_rst,
    // CPU internal bus.
    input  wire eepc_bus_req_t i_bus,
    output logic [7:0]         o_rdata,
    output logic               o_rdata_valid,
    // Clock source choice from the options register.
    input  wire logic          i_rc_clock_select,
    // Charge pump state.
    output logic               o_high_voltage
);

    // A divider of one would leave its tick stuck high, so values below two stop elaboration.
    if (E_DIV < 2 || E_DIV > 65535 || RC_DIV < 2 || RC_DIV > 65535) begin : g_div_check
        $error("eepc_ctrl: clock dividers must lie in 2..65535");
    end

    localparam logic [15:0] E_LAST  = 16'(E_DIV - 1);
    localparam logic [15:0] RC_LAST = 16'(RC_DIV - 1);

    // Storage and control state.
    logic [7:0] mem_r [512];
    logic [7:0] setup_cell_r;
    logic [7:0] prog_ctrl_r;
    logic [4:0] block_prot_r;
    logic [15:0] e_div_r;
    logic [15:0] rc_div_r;
    logic        e_tick_r;
    logic        rc_tick_r;
    logic [6:0]  window_cnt_r;
    logic        window_open_r;
    logic [8:0]  lat_addr_r;
    logic        lat_setup_r;
    logic [7:0]  lat_data_r;
    logic        lat_written_r;
    logic        op_pend_r;

    // Address decode.
    logic       hit_array;
    logic       hit_setup;
    logic       hit_pc;
    logic       hit_bp;
    logic [7:0] wd;
    assign hit_array = (i_bus.addr[15:9] == 7'(`EEPC_ADDR_ARRAY_BASE >> 9));
    assign hit_setup = (i_bus.addr == `EEPC_ADDR_SETUP_CELL);
    assign hit_pc    = (i_bus.addr == `EEPC_ADDR_PROGRAM_CONTROL);
    assign hit_bp    = (i_bus.addr == `EEPC_ADDR_BLOCK_PROTECT);
    assign wd        = i_bus.data;

    logic latch_on;
    logic pgm_on;
    assign latch_on = prog_ctrl_r[`EEPC_PC_LATCH];
    assign pgm_on   = prog_ctrl_r[`EEPC_PC_PGM];

    // E-clock and RC-clock enables; the pump follows whichever is selected.
    always_ff @(posedge i_clock) begin
        if (i_rst || e_div_r == E_LAST) begin
            e_div_r <= 16'h0000;
        end else begin
            e_div_r <= e_div_r + 16'h0001;
        end
        e_tick_r <= !i_rst && (e_div_r == E_LAST);
    end

    always_ff @(posedge i_clock) begin
        if (i_rst || rc_div_r == RC_LAST) begin
            rc_div_r <= 16'h0000;
        end else begin
            rc_div_r <= rc_div_r + 16'h0001;
        end
        rc_tick_r <= !i_rst && (rc_div_r == RC_LAST);
    end

    logic pump_tick;
    assign pump_tick = i_rc_clock_select ? rc_tick_r : e_tick_r;

    // Protection window after reset, counted in E cycles.
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            window_cnt_r  <= 7'h00;
            window_open_r <= 1'b1;
        end else if (e_tick_r && window_open_r) begin
            window_cnt_r <= window_cnt_r + 7'h01;
            if (window_cnt_r == 7'(`EEPC_PROTECT_WINDOW_E - 1)) begin
                window_open_r <= 1'b0;
            end
        end
    end

    // Set bits any time, clear only while the window is open.
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            block_prot_r <= `EEPC_BP_RESET;
        end else if (i_bus.wr && hit_bp) begin
            if (window_open_r) begin
                block_prot_r <= wd[`EEPC_BP_SETUP:0];
            end else begin
                block_prot_r <= block_prot_r | wd[`EEPC_BP_SETUP:0];
            end
        end
    end

    // Control register write, with the runaway safeguards on latch and voltage.
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            prog_ctrl_r <= `EEPC_PC_RESET;
        end else if (i_bus.wr && hit_pc) begin
            prog_ctrl_r[`EEPC_PC_ODD]   <= wd[`EEPC_PC_ODD];
            prog_ctrl_r[`EEPC_PC_EVEN]  <= wd[`EEPC_PC_EVEN];
            prog_ctrl_r[5]              <= 1'b0;
            prog_ctrl_r[`EEPC_PC_BYTE]  <= wd[`EEPC_PC_BYTE];
            prog_ctrl_r[`EEPC_PC_ROW]   <= wd[`EEPC_PC_ROW];
            prog_ctrl_r[`EEPC_PC_ERASE] <= wd[`EEPC_PC_ERASE];
            prog_ctrl_r[`EEPC_PC_LATCH] <= wd[`EEPC_PC_LATCH]
                && !(!latch_on && wd[`EEPC_PC_PGM]);
            prog_ctrl_r[`EEPC_PC_PGM]   <= latch_on && wd[`EEPC_PC_LATCH]
                && wd[`EEPC_PC_PGM];
        end
    end

    // Capture of the target while latched and before the voltage is on.
    always_ff @(posedge i_clock) begin
        if (i_rst || !latch_on) begin
            lat_addr_r    <= 9'h000;
            lat_setup_r   <= 1'b0;
            lat_data_r    <= `EEPC_ERASED;
            lat_written_r <= 1'b0;
        end else if (i_bus.wr && (hit_array || hit_setup) && !pgm_on) begin
            lat_addr_r    <= i_bus.addr[8:0];
            lat_setup_r   <= hit_setup;
            lat_data_r    <= wd;
            lat_written_r <= 1'b1;
        end
    end

    // One operation is armed per rise of the voltage bit, and only after a capture.
    logic pgm_rise;
    assign pgm_rise = i_bus.wr && hit_pc && latch_on && !pgm_on
        && wd[`EEPC_PC_LATCH] && wd[`EEPC_PC_PGM];

    always_ff @(posedge i_clock) begin
        if (i_rst || !pgm_on) begin
            op_pend_r <= pgm_rise && lat_written_r;
        end else if (pump_tick) begin
            op_pend_r <= 1'b0;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            o_high_voltage <= 1'b0;
        end else begin
            o_high_voltage <= pgm_on;
        end
    end

    // Region index of an array offset.
    function automatic logic [1:0] region_of(input logic [8:0] off);
        if (off < `EEPC_REGION1_START) begin
            region_of = 2'd0;
        end else if (off < `EEPC_REGION2_START) begin
            region_of = 2'd1;
        end else if (off < `EEPC_REGION3_START) begin
            region_of = 2'd2;
        end else begin
            region_of = 2'd3;
        end
    endfunction : region_of

    eepc_op_t op;
    logic     target_prot;
    logic     do_op;
    always_comb begin
        if (!prog_ctrl_r[`EEPC_PC_ERASE]) begin
            op = EEPC_OP_PROGRAM;
        end else if (prog_ctrl_r[`EEPC_PC_BYTE]) begin
            op = EEPC_OP_BYTE;
        end else if (prog_ctrl_r[`EEPC_PC_ROW]) begin
            op = EEPC_OP_ROW;
        end else begin
            op = EEPC_OP_BULK;
        end
        case (op)
            EEPC_OP_BULK: begin
                // A bulk erase spans every region, so any set region protect bit refuses it; the setup bit only when latched at the setup cell.
                target_prot = (|block_prot_r[`EEPC_BP_MSB:0])
                    || (lat_setup_r && block_prot_r[`EEPC_BP_SETUP]);
            end
            default: begin
                if (lat_setup_r) begin
                    target_prot = block_prot_r[`EEPC_BP_SETUP];
                end else begin
                    target_prot = block_prot_r[region_of(lat_addr_r)];
                end
            end
        endcase
        do_op = op_pend_r && pump_tick && pgm_on && !target_prot;
    end

    // Array cells; contents survive reset as a nonvolatile store would.
    always_ff @(posedge i_clock) begin
        if (do_op) begin
            for (int i = 0; i < 512; i++) begin
                case (op)
                    EEPC_OP_PROGRAM: begin
                        if (!lat_setup_r && lat_addr_r == 9'(i)) begin
                            mem_r[i] <= mem_r[i] & lat_data_r;
                        end
                    end
                    EEPC_OP_BYTE: begin
                        if (!lat_setup_r && lat_addr_r == 9'(i)) begin
                            mem_r[i] <= `EEPC_ERASED;
                        end
                    end
                    EEPC_OP_ROW: begin
                        if (!lat_setup_r && lat_addr_r[8:4] == 5'(i >> 4)) begin
                            mem_r[i] <= `EEPC_ERASED;
                        end
                    end
                    default: begin
                        mem_r[i] <= `EEPC_ERASED;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge i_clock) begin
        if (do_op && lat_setup_r) begin
            case (op)
                EEPC_OP_PROGRAM: begin
                    setup_cell_r <= setup_cell_r & lat_data_r;
                end
                default: begin
                    setup_cell_r <= `EEPC_ERASED;
                end
            endcase
        end
    end

    // Read path; protection plays no part, and while latched the array reads back
    // the captured byte because its data path is turned to programming.
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            o_rdata       <= 8'h00;
            o_rdata_valid <= 1'b0;
        end else begin
            o_rdata_valid <= i_bus.rd && (hit_array || hit_setup || hit_pc || hit_bp);
            if (!i_bus.rd) begin
                o_rdata <= 8'h00;
            end else if (hit_array) begin
                o_rdata <= latch_on ? lat_data_r : mem_r[i_bus.addr[8:0]];
            end else if (hit_setup) begin
                o_rdata <= latch_on ? lat_data_r : setup_cell_r;
            end else if (hit_pc) begin
                o_rdata <= prog_ctrl_r;
            end else if (hit_bp) begin
                o_rdata <= {3'b000, block_prot_r};
            end else begin
                o_rdata <= 8'h00;
            end
        end
    end

endmodule : eepc_ctrl
`default_nettype wire

// >>> verif/eepc_ctrl_monitor.sv
// Checker for the bus answers and charge pump state of the EEPROM controller.
`timescale 1ns/1ns
`default_nettype none
`include "eepc_defs.svh"
module eepc_ctrl_monitor
    import eepc_pkg::*;
#(
    parameter int E_DIV  = `EEPC_E_DIV,
    parameter int RC_DIV = `EEPC_RC_DIV
) (
    input wire logic          i_clock,
    input wire logic          i_rst,
    input wire eepc_bus_req_t i_bus,
    input wire logic [7:0]    o_rdata,
    input wire logic          o_rdata_valid,
    input wire logic          i_rc_clock_select,
    input wire logic          o_high_voltage
);
    logic cw;
    logic cw_on;
    logic cw_off;
    logic hit;
    assign cw     = i_bus.wr && i_bus.addr == `EEPC_ADDR_PROGRAM_CONTROL;
    assign cw_on  = cw && (&i_bus.data[1:0]);
    assign cw_off = cw && !(&i_bus.data[1:0]);
    assign hit    = i_bus.addr == `EEPC_ADDR_BLOCK_PROTECT || i_bus.addr[15:9] == 7'h7F
                 || i_bus.addr == `EEPC_ADDR_PROGRAM_CONTROL
                 || i_bus.addr == `EEPC_ADDR_SETUP_CELL;
    default clocking @(posedge i_clock); endclocking
    default disable iff (i_rst);
    rd_answer_a: assert property (
        i_bus.rd && hit |=> o_rdata_valid)
        else $error("mapped read got no answer");
    rd_unmapped_a: assert property (
        i_bus.rd && !hit |=> !o_rdata_valid && o_rdata == 8'h00)
        else $error("unmapped read answered");
    rd_single_a: assert property (
        !i_bus.rd |=> !o_rdata_valid)
        else $error("answer without a read");
    ctrl_bit5_a: assert property (
        i_bus.rd && i_bus.addr == `EEPC_ADDR_PROGRAM_CONTROL |=> o_rdata[5] == 1'b0)
        else $error("control bit 5 not zero");
    hv_rise_a: assert property (
        $rose(o_high_voltage) |-> $past(cw_on) || $past(cw_on, 2))
        else $error("pump on without a voltage write");
    hv_fall_a: assert property (
        $fell(o_high_voltage) |-> $past(cw_off) || $past(cw_off, 2))
        else $error("pump off without a clearing write");
    hv_drop_a: assert property (
        cw_off |-> ##[1:2] !o_high_voltage)
        else $error("pump still on after clearing write");
    reset_quiet_a: assert property (
        $fell(i_rst) |-> !o_high_voltage && !o_rdata_valid)
        else $error("outputs active after reset");
    cover property (cw_on ##2 o_high_voltage);
    cover property (i_bus.rd && !hit);
    cover property (cw_off ##2 $fell(o_high_voltage));
endmodule : eepc_ctrl_monitor
bind eepc_ctrl eepc_ctrl_monitor #(.E_DIV(E_DIV), .RC_DIV(RC_DIV)) u_mon (
    .i_clock(i_clock), .i_rst(i_rst), .i_bus(i_bus), .o_rdata(o_rdata),
    .o_rdata_valid(o_rdata_valid), .i_rc_clock_select(i_rc_clock_select),
    .o_high_voltage(o_high_voltage));
`default_nettype wire

// >>> verif/eepc_cpu_bfm.sv
// CPU core model that drives the controller's internal bus.
`timescale 1ns/1ns
`default_nettype none
module eepc_cpu_bfm
    import eepc_pkg::*;
(
    input  wire logic     i_clock,
    output var eepc_bus_req_t o_bus
);
    initial o_bus = '0;
    // A released bus shows inverted values so stale data never passes for valid.
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge i_clock);
        o_bus <= '{a, 1'b1, 1'b0, d};
        @(posedge i_clock);
        o_bus <= '{~a, 1'b0, 1'b0, ~d};
    endtask : wr
    task automatic rd(input logic [15:0] a);
        @(posedge i_clock);
        o_bus <= '{a, 1'b0, 1'b1, 8'h00};
        @(posedge i_clock);
        o_bus <= '{~a, 1'b0, 1'b0, 8'hFF};
        #1;
    endtask : rd
    // The wait stands for the long pump delay and spans several pump ticks.
    task automatic op(input logic [7:0] m, input logic [15:0] a, input logic [7:0] d);
        wr(16'h103B, m | 8'h02);
        wr(a, d);
        wr(16'h103B, m | 8'h03);
        repeat (12) @(posedge i_clock);
        wr(16'h103B, 8'h00);
    endtask : op
endmodule : eepc_cpu_bfm
`default_nettype wire

// >>> verif/tb_top.sv
// Self-checking bench for the EEPROM program and erase controller.
`timescale 1ns/1ns
`default_nettype none
module tb_top
    import eepc_pkg::*;
;
    logic          i_clock = 1'b0;
    logic          i_rst   = 1'b1;
    logic          rc_sel  = 1'b0;
    eepc_bus_req_t bus;
    logic [7:0]    o_rdata;
    logic          o_rdata_valid;
    logic          o_high_voltage;
    int            n_fail = 0;
    int            cmp_count = 0;
    int            cyc = 0;
    logic [8:0]    off;
    logic [8:0]    off2;
    logic [7:0]    d;
    always #5 i_clock = ~i_clock;
    eepc_cpu_bfm u_cpu (.i_clock(i_clock), .o_bus(bus));
    eepc_ctrl #(.E_DIV(2), .RC_DIV(3)) u_dut (
        .i_clock(i_clock), .i_rst(i_rst), .i_bus(bus), .o_rdata(o_rdata),
        .o_rdata_valid(o_rdata_valid), .i_rc_clock_select(rc_sel),
        .o_high_voltage(o_high_voltage));
    function automatic logic [15:0] ea(input logic [8:0] o);
        return 16'hFE00 + {7'h00, o};
    endfunction : ea
    // Programming can only clear bits, so the cell ends as the AND of old and new.
    function automatic logic [7:0] prog_exp(input logic [7:0] old, input logic [7:0] nw);
        return old & nw;
    endfunction : prog_exp
    task automatic check(input logic [8:0] seen, input logic [8:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic rchk(input logic [15:0] a, input logic [8:0] exp);
        u_cpu.rd(a);
        check({o_rdata_valid, o_rdata}, exp);
    endtask : rchk
    task automatic run(input logic [7:0] m, input logic [15:0] a, input logic [7:0] dd);
        @(posedge i_clock);
        rc_sel <= 1'($urandom_range(0, 1));
        u_cpu.op(m, a, dd);
    endtask : run
    task automatic print_verdict;
        if (n_fail == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : print_verdict
    always @(posedge i_clock) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            print_verdict();
        end
    end
    initial begin
        void'($urandom(32'h1B6C));
        repeat (10) @(posedge i_clock);
        i_rst <= 1'b0;
        rchk(16'h103B, 9'h100);
        rchk(16'h1035, 9'h11F);
        u_cpu.wr(16'h1035, 8'h00);
        rchk(16'h1035, 9'h100);
        off = 9'h100 + 9'($urandom_range(0, 255));
        off2 = off - 9'h080;
        // An all-ones byte would hide a missed program or a stray erase, so it is never drawn.
        d = 8'($urandom_range(0, 254));
        run(8'h04, 16'h103F, d);
        rchk(16'h103F, 9'h1FF);
        rchk(ea(off), 9'h1FF);
        run(8'h18, ea(off), d);
        rchk(ea(off), {1'b1, prog_exp(8'hFF, d)});
        u_cpu.wr(16'h103B, 8'h02);
        u_cpu.wr(ea(off), 8'hA5);
        rchk(ea(off), 9'h1A5);
        u_cpu.wr(16'h103B, 8'h00);
        u_cpu.wr(16'h103B, 8'h03);
        rchk(16'h103B, 9'h100);
        // Latch then voltage with no array write between: the bulk erase must not happen.
        u_cpu.wr(16'h103B, 8'h06);
        u_cpu.wr(16'h103B, 8'h07);
        @(posedge i_clock);
        #1;
        check({8'h00, o_high_voltage}, 9'h001);
        rchk(16'h103B, 9'h107);
        repeat (12) @(posedge i_clock);
        u_cpu.wr(16'h103B, 8'h00);
        rchk(ea(off), {1'b1, prog_exp(8'hFF, d)});
        u_cpu.wr(16'h103B, 8'h02);
        u_cpu.wr(ea(off2), 8'h5C);
        u_cpu.wr(16'h103B, 8'h03);
        u_cpu.wr(ea(off), 8'h00);
        repeat (12) @(posedge i_clock);
        rchk(ea(off), 9'h15C);
        u_cpu.wr(16'h103B, 8'h00);
        @(posedge i_clock);
        #1;
        check({8'h00, o_high_voltage}, 9'h000);
        rchk(ea(off), {1'b1, prog_exp(8'hFF, d)});
        rchk(ea(off2), {1'b1, prog_exp(8'hFF, 8'h5C)});
        run(8'h0C, ea(off2 ^ 9'h00F), 8'h00);
        rchk(ea(off2), 9'h1FF);
        rchk(ea(off), {1'b1, prog_exp(8'hFF, d)});
        run(8'h00, ea(off ^ 9'h001), 8'h00);
        run(8'h1C, ea(off), 8'h00);
        rchk(ea(off), 9'h1FF);
        rchk(ea(off ^ 9'h001), 9'h100);
        u_cpu.wr(16'h103B, 8'h04);
        rchk(16'h103B, 9'h104);
        u_cpu.wr(16'h103B, 8'h00);
        repeat (130) @(posedge i_clock);
        u_cpu.wr(16'h1035, 8'h01);
        u_cpu.wr(16'h1035, 8'h00);
        rchk(16'h1035, 9'h101);
        run(8'h04, ea(9'h1F0), 8'h00);
        rchk(ea(off ^ 9'h001), 9'h100);
        run(8'h00, ea(9'h010), 8'h00);
        rchk(ea(9'h010), 9'h1FF);
        run(8'h00, ea(9'h030), d);
        rchk(ea(9'h030), {1'b1, prog_exp(8'hFF, d)});
        u_cpu.wr(16'h1035, 8'h10);
        run(8'h00, 16'h103F, 8'h00);
        rchk(16'h103F, 9'h1FF);
        rchk(16'h2000, 9'h000);
        // A second reset restores the registers but must leave the cells intact.
        @(posedge i_clock);
        i_rst <= 1'b1;
        repeat (3) @(posedge i_clock);
        i_rst <= 1'b0;
        rchk(16'h1035, 9'h11F);
        rchk(16'h103B, 9'h100);
        rchk(ea(9'h030), {1'b1, prog_exp(8'hFF, d)});
        print_verdict();
    end
endmodule : tb_top
`default_nettype wire
